// ==== rtl/gpalt_pkg.sv ====
// constants shared by the three-port pin block: register indices,
// reset values, field positions and interrupt sensitivity codes.
// assumes a wishbone slave with 32-bit data, registers on word indices.
package gpalt_pkg;
    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_PA_LATCH = 4'h0;
    localparam logic [3:0] IDX_PA_DIR = 4'h1;
    localparam logic [3:0] IDX_PB_LATCH = 4'h2;
    localparam logic [3:0] IDX_PB_DIR = 4'h3;
    localparam logic [3:0] IDX_PC_LATCH = 4'h4;
    localparam logic [3:0] IDX_PC_DIR = 4'h5;
    localparam logic [3:0] IDX_IRQ_CFG1 = 4'h8;
    localparam logic [3:0] IDX_IRQ_CFG2 = 4'h9;
    localparam logic [3:0] IDX_MISC = 4'ha;
    localparam logic [3:0] IDX_IRQ_SENS = 4'hb;

    // values after reset
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [5:0] PULLUP_RST = 6'h3f;
    localparam logic PREV_RST = 1'b1;

    // misc_control_reg bit positions
    localparam int MISC_CLKOUT_BIT = 0;
    localparam int MISC_USBTX_BIT = 1;

    // irq_sensitivity_field positions in the sensitivity register
    localparam int SENS_A_LSB = 0;
    localparam int SENS_B_LSB = 2;
    localparam int SENS_C_LSB = 4;

    // irq_sensitivity_field codes
    localparam logic [1:0] SENS_FALL_LOW = 2'b00;
    localparam logic [1:0] SENS_RISE = 2'b01;
    localparam logic [1:0] SENS_FALL = 2'b10;
    localparam logic [1:0] SENS_BOTH = 2'b11;
endpackage

// ==== rtl/gpalt_ports.sv ====
// three 8-pin ports with direction, latch, alternate functions and
// grouped external interrupt requests, behind a classic wishbone slave.
// assumes pin inputs synchronous to CORE_CLK; pads resolve OUT/OE.
//
// Contract
// - direction bit x sets pin x, 1 output
// - eight pins, each direction set independently
// - input pin reads back the pin level
// - output pin drives latch (pc0-1 open drain, drive only a low latch), reads return latch
// - output pins never raise external interrupts; peripheral-driven pins with dir low still can
// - enabled input pin event raises interrupt request
// - group pins combined by inverted AND
// - peripheral function overrides direction and latch
// - peripheral output forces pin to output mode
// - peripheral input pins still readable as level
// - converter channel select routes port A pins
// - port A 0-3 interrupts, pin 0 usb enable
// - port B alternate functions and interrupts 5-8
// - port C interrupts 9-12 and SPI pins
// - two-bit sensitivity selects edge or level trigger
// - latch writes always stored, even as input
`timescale 1ns/10ps
module gpalt_ports (
    input wire logic CORE_CLK, // 250 MHz cpu clock
    input wire logic RESET, // async, active high
    input wire logic CE, // clock enable, freezes all state when low
    input wire logic CYC_I, // wishbone cycle
    input wire logic STB_I, // wishbone strobe
    input wire logic WE_I, // wishbone write
    input wire logic [5:0] ADR_I, // byte address
    input wire logic [3:0] SEL_I, // byte selects, lane 0 used
    input wire logic [31:0] DAT_I, // write data
    output logic [31:0] DAT_O, // read data
    output logic ACK_O, // wishbone acknowledge
    input wire logic [7:0] PA_IN, // port A pin levels
    output logic [7:0] PA_OUT, // port A drive value
    output logic [7:0] PA_OE, // port A drive enable
    input wire logic [7:0] PB_IN, // port B pin levels
    output logic [7:0] PB_OUT, // port B drive value
    output logic [7:0] PB_OE, // port B drive enable
    input wire logic [7:0] PC_IN, // port C pin levels
    output logic [7:0] PC_OUT, // port C drive value
    output logic [7:0] PC_OE, // port C drive enable
    output logic [5:0] PC_PULLUP, // pull-ups of port C pins 7..2
    output logic IRQ_PORT_A, // request, interrupts 1-4
    output logic IRQ_PORT_B, // request, interrupts 5-8
    output logic IRQ_PORT_C, // request, interrupts 9-12
    input wire logic USB_TX_ACTIVE, // usb_tx_enable_out source
    input wire logic CLK_OUT_SRC, // cpu_clock_out source
    input wire logic SCI_TX_EN, // serial transmitter enabled
    input wire logic SCI_TXD, // serial transmit data
    output logic SERIAL_RX, // serial_receive_in to the sci
    output logic TIMER_CLK_IN, // timer_ext_clock_in to the timer
    output logic [1:0] TIMER_CAPTURE, // timer_capture_two, _one
    input wire logic [1:0] PULSE_OE, // pulse_out_two, _one enables
    input wire logic [1:0] PULSE_OUT, // pulse_out_two, _one values
    input wire logic SPI_EN, // spi enabled
    input wire logic [3:0] SPI_DRV_OE, // mosi, miso, ss, sck drive
    input wire logic [3:0] SPI_DRV, // mosi, miso, ss, sck values
    output logic [3:0] SPI_PIN_IN, // mosi, miso, ss, sck levels
    input wire logic ADC_ON, // converter active
    input wire logic [2:0] ADC_CHSEL, // converter channel select
    output logic [7:0] ANALOG_SEL // one-hot analog switch enables
);
    import gpalt_pkg::*;

    // read mux: output bits give the latch, input bits the pin
    function automatic logic [7:0] read_bits(input logic [7:0] dir,
            input logic [7:0] lat, input logic [7:0] pin);
        read_bits = (dir & lat) | (~dir & pin);
    endfunction

    // inverted-and combine, low while any enabled input pin is low
    function automatic logic group_level(input logic [3:0] pin,
            input logic [3:0] en, input logic [3:0] dir);
        group_level = &(pin | ~(en & ~dir));
    endfunction

    // trigger decision from the sensitivity code and the two levels
    // mode 00 is kept as a level, its falling edge is that level
    function automatic logic trigger(input logic [1:0] sens,
            input logic prev, input logic now);
        case (sens)
            SENS_FALL_LOW: trigger = ~now;
            SENS_RISE: trigger = ~prev & now;
            SENS_FALL: trigger = prev & ~now;
            SENS_BOTH: trigger = prev ^ now;
            default: trigger = 1'b0;
        endcase
    endfunction

    logic [7:0] latch_a, latch_b, latch_c;
    logic [7:0] dir_a, dir_b, dir_c;
    logic [7:0] irq_cfg1, irq_cfg2, misc, irq_sens;
    logic [7:0] next_latch_a, next_latch_b, next_latch_c;
    logic [7:0] next_dir_a, next_dir_b, next_dir_c;
    logic [7:0] next_irq_cfg1, next_irq_cfg2, next_misc, next_irq_sens;
    logic [31:0] next_dat;
    logic next_ack;
    logic [3:0] idx;
    logic wr;

    assign idx = ADR_I[5:2];
    // one-wait slave: ack the cycle after strobe, drop it the next
    // the ~ACK_O term keeps a strobe still held in the ack cycle
    // from writing a second time
    assign wr = CYC_I & STB_I & WE_I & ~ACK_O & SEL_I[0];

    // register file next values
    always_comb begin
        next_latch_a = latch_a;
        next_latch_b = latch_b;
        next_latch_c = latch_c;
        next_dir_a = dir_a;
        next_dir_b = dir_b;
        next_dir_c = dir_c;
        next_irq_cfg1 = irq_cfg1;
        next_irq_cfg2 = irq_cfg2;
        next_misc = misc;
        next_irq_sens = irq_sens;
        next_ack = CYC_I & STB_I & ~ACK_O;
        next_dat = DAT_O;
        if (wr) begin
            // latch stores even for input pins
            case (idx)
                IDX_PA_LATCH: next_latch_a = DAT_I[7:0];
                IDX_PA_DIR: next_dir_a = DAT_I[7:0];
                IDX_PB_LATCH: next_latch_b = DAT_I[7:0];
                IDX_PB_DIR: next_dir_b = DAT_I[7:0];
                IDX_PC_LATCH: next_latch_c = DAT_I[7:0];
                IDX_PC_DIR: next_dir_c = DAT_I[7:0];
                IDX_IRQ_CFG1: next_irq_cfg1 = DAT_I[7:0];
                IDX_IRQ_CFG2: next_irq_cfg2 = {4'h0, DAT_I[3:0]};
                IDX_MISC: next_misc = {6'h00, DAT_I[1:0]};
                IDX_IRQ_SENS: next_irq_sens = {2'h0, DAT_I[5:0]};
                default: ; // unmapped writes are dropped
            endcase
        end
        // pin levels are taken at the taking edge; a pin that moves
        // during the ack cycle shows up only on the next read
        if (CYC_I & STB_I & ~ACK_O) begin
            next_dat = 32'h0000_0000;
            case (idx)
                IDX_PA_LATCH: next_dat[7:0] = read_bits(dir_a, latch_a,
                    PA_IN);
                IDX_PA_DIR: next_dat[7:0] = dir_a;
                IDX_PB_LATCH: next_dat[7:0] = read_bits(dir_b, latch_b,
                    PB_IN);
                IDX_PB_DIR: next_dat[7:0] = dir_b;
                IDX_PC_LATCH: next_dat[7:0] = read_bits(dir_c, latch_c,
                    PC_IN);
                IDX_PC_DIR: next_dat[7:0] = dir_c;
                IDX_IRQ_CFG1: next_dat[7:0] = irq_cfg1;
                IDX_IRQ_CFG2: next_dat[7:0] = irq_cfg2;
                IDX_MISC: next_dat[7:0] = misc;
                IDX_IRQ_SENS: next_dat[7:0] = irq_sens;
                default: next_dat = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // register file flops
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            latch_a <= LATCH_RST;
            latch_b <= LATCH_RST;
            latch_c <= LATCH_RST;
            dir_a <= DIR_RST; // all pins start as inputs
            dir_b <= DIR_RST;
            dir_c <= DIR_RST;
            irq_cfg1 <= CFG_RST;
            irq_cfg2 <= CFG_RST;
            misc <= CFG_RST;
            irq_sens <= CFG_RST;
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else if (CE) begin
            latch_a <= next_latch_a;
            latch_b <= next_latch_b;
            latch_c <= next_latch_c;
            dir_a <= next_dir_a;
            dir_b <= next_dir_b;
            dir_c <= next_dir_c;
            irq_cfg1 <= next_irq_cfg1;
            irq_cfg2 <= next_irq_cfg2;
            misc <= next_misc;
            irq_sens <= next_irq_sens;
            ACK_O <= next_ack;
            DAT_O <= next_dat;
        end
    end

    logic [7:0] next_pa_out, next_pa_oe, next_pb_out, next_pb_oe;
    logic [7:0] next_pc_out, next_pc_oe, next_analog;
    logic [5:0] next_pullup;
    logic [2:0] grp_now, grp_prev, next_irq;
    logic [1:0] next_capture;
    logic [3:0] next_spi_in;
    logic next_rx, next_tclk;

    // pin drive, peripheral routing and interrupt requests
    always_comb begin
        // plain i/o: direction selects drive, latch gives value
        next_pa_oe = dir_a;
        next_pa_out = latch_a;
        next_pb_oe = dir_b;
        next_pb_out = latch_b;
        // pc0-1 true open drain: only ever pull low
        next_pc_oe = {dir_c[7:2], dir_c[1:0] & ~latch_c[1:0]};
        next_pc_out = {latch_c[7:2], 2'b00};
        // peripheral outputs win over direction and latch
        if (misc[MISC_USBTX_BIT]) begin
            next_pa_oe[0] = 1'b1;
            next_pa_out[0] = USB_TX_ACTIVE;
        end
        if (misc[MISC_CLKOUT_BIT]) begin
            next_pb_oe[0] = 1'b1;
            next_pb_out[0] = CLK_OUT_SRC;
        end
        if (SCI_TX_EN) begin
            next_pb_oe[2] = 1'b1;
            next_pb_out[2] = SCI_TXD;
        end
        for (int i = 0; i < 2; i++) begin
            if (PULSE_OE[i]) begin
                next_pb_oe[6 + i] = 1'b1;
                next_pb_out[6 + i] = PULSE_OUT[i];
            end
        end
        // spi owns pc3-6; bidirectional pins rely on dir low
        if (SPI_EN) begin
            next_pc_oe[6:3] = SPI_DRV_OE;
            next_pc_out[6:3] = SPI_DRV;
        end
        // pull-ups only while the pin is not driven
        next_pullup = ~next_pc_oe[7:2];
        // peripheral inputs take the pin level directly
        next_rx = PB_IN[1];
        next_tclk = PB_IN[3];
        next_capture = PB_IN[5:4];
        next_spi_in = PC_IN[6:3];
        // converter switch, one pin per channel code
        next_analog = ADC_ON ? (8'h01 << ADC_CHSEL) : 8'h00;
        // one low pin holds its group low and so hides the others
        // group levels; pin must also be an input
        grp_now[0] = group_level(PA_IN[3:0], irq_cfg1[3:0],
            dir_a[3:0]);
        grp_now[1] = group_level(PB_IN[7:4], irq_cfg1[7:4],
            dir_b[7:4]);
        grp_now[2] = group_level(PC_IN[5:2], irq_cfg2[3:0],
            dir_c[5:2]);
        next_irq[0] = trigger(irq_sens[SENS_A_LSB +: 2], grp_prev[0],
            grp_now[0]);
        next_irq[1] = trigger(irq_sens[SENS_B_LSB +: 2], grp_prev[1],
            grp_now[1]);
        next_irq[2] = trigger(irq_sens[SENS_C_LSB +: 2], grp_prev[2],
            grp_now[2]);
    end

    // pin and request flops; outputs leave straight from here
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            PA_OUT <= 8'h00;
            PA_OE <= 8'h00; // floating inputs at reset
            PB_OUT <= 8'h00;
            PB_OE <= 8'h00;
            PC_OUT <= 8'h00;
            PC_OE <= 8'h00;
            PC_PULLUP <= PULLUP_RST;
            SERIAL_RX <= 1'b0;
            TIMER_CLK_IN <= 1'b0;
            TIMER_CAPTURE <= 2'b00;
            SPI_PIN_IN <= 4'h0;
            ANALOG_SEL <= 8'h00;
            grp_prev <= {3{PREV_RST}};
            IRQ_PORT_A <= 1'b0;
            IRQ_PORT_B <= 1'b0;
            IRQ_PORT_C <= 1'b0;
        end else if (CE) begin
            PA_OUT <= next_pa_out;
            PA_OE <= next_pa_oe;
            PB_OUT <= next_pb_out;
            PB_OE <= next_pb_oe;
            PC_OUT <= next_pc_out;
            PC_OE <= next_pc_oe;
            PC_PULLUP <= next_pullup;
            SERIAL_RX <= next_rx;
            TIMER_CLK_IN <= next_tclk;
            TIMER_CAPTURE <= next_capture;
            SPI_PIN_IN <= next_spi_in;
            ANALOG_SEL <= next_analog;
            grp_prev <= grp_now;
            IRQ_PORT_A <= next_irq[0];
            IRQ_PORT_B <= next_irq[1];
            IRQ_PORT_C <= next_irq[2];
        end
    end
endmodule // gpalt_ports

// ==== verif/gpalt_ports_checker.sv ====
// checker on the pin block ports: bus answer timing and pin routing
// assumes CE held high by the bench; bound into every block instance
`timescale 1ns/10ps
module gpalt_ports_checker (
    input wire logic CORE_CLK, // cpu clock
    input wire logic RESET, // async reset
    input wire logic CE, // clock enable
    input wire logic CYC_I, // bus cycle
    input wire logic STB_I, // bus strobe
    input wire logic ACK_O, // bus acknowledge
    input wire logic ADC_ON, // converter active
    input wire logic [2:0] ADC_CHSEL, // channel select
    input wire logic [7:0] ANALOG_SEL, // analog switches
    input wire logic [7:0] PB_IN, // port B levels
    input wire logic TIMER_CLK_IN, // timer clock in
    input wire logic [1:0] TIMER_CAPTURE, // timer captures
    input wire logic SERIAL_RX, // serial receive
    input wire logic [7:0] PC_IN, // port C levels
    input wire logic [3:0] SPI_PIN_IN, // spi pin levels
    input wire logic [7:0] PC_OUT, // port C drive
    input wire logic [7:0] PC_OE, // port C enable
    input wire logic [5:0] PC_PULLUP, // port C pull-ups
    input wire logic [1:0] PULSE_OE, // pulse enables
    input wire logic [1:0] PULSE_OUT, // pulse values
    input wire logic [7:0] PB_OE, // port B enable
    input wire logic [7:0] PB_OUT // port B drive
);
    // a frozen clock enable holds every flop, so checks pause with it
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET || !CE);
    // a request the slave has not yet answered
    sequence bus_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    ack_answer_a: assert property (bus_req |=> ACK_O)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (ACK_O |=> !ACK_O)
        else $error("acknowledge held longer than one cycle");
    analog_sel_a: assert property (!RESET |=> ANALOG_SEL ==
        ($past(ADC_ON) ? (8'h01 << $past(ADC_CHSEL)) : 8'h00))
        else $error("analog switch does not follow channel select");
    // the reset edge itself is skipped: flops hold reset values there
    serial_rx_a: assert property (!RESET |=>
        SERIAL_RX == $past(PB_IN[1]))
        else $error("serial receive not routed from port B pin 1");
    spi_pin_a: assert property (!RESET |=>
        SPI_PIN_IN == $past(PC_IN[6:3]))
        else $error("spi pin levels not routed from port C");
    timer_route_a: assert property (!RESET |=>
        {TIMER_CAPTURE, TIMER_CLK_IN} == $past(PB_IN[5:3]))
        else $error("timer inputs not routed from port B");
    open_drain_a: assert property (PC_OUT[1:0] == 2'b00)
        else $error("open drain pin drives high");
    pullup_a: assert property (PC_PULLUP == ~PC_OE[7:2])
        else $error("pull-up active on a driven pin");
    pulse_force_a: assert property (PULSE_OE[0] |=> PB_OE[6] &&
        PB_OUT[6] == $past(PULSE_OUT[0]))
        else $error("pulse output does not own port B pin 6");
endmodule // gpalt_ports_checker

bind gpalt_ports gpalt_ports_checker chk_u (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .CE(CE), .CYC_I(CYC_I),
    .STB_I(STB_I), .ACK_O(ACK_O), .ADC_ON(ADC_ON), .ADC_CHSEL(ADC_CHSEL),
    .ANALOG_SEL(ANALOG_SEL), .PB_IN(PB_IN), .SERIAL_RX(SERIAL_RX),
    .TIMER_CLK_IN(TIMER_CLK_IN), .TIMER_CAPTURE(TIMER_CAPTURE),
    .PC_IN(PC_IN), .SPI_PIN_IN(SPI_PIN_IN), .PC_OUT(PC_OUT), .PC_OE(PC_OE),
    .PC_PULLUP(PC_PULLUP), .PULSE_OE(PULSE_OE), .PULSE_OUT(PULSE_OUT),
    .PB_OE(PB_OE), .PB_OUT(PB_OUT));

// ==== verif/gpalt_board.sv ====
// board model: resolves one 8-pin port from block and board drive
// assumes the bench never drives a pin while the block drives it
`timescale 1ns/10ps
module gpalt_board (
    input wire logic clk, // cpu clock
    input wire logic [7:0] out, // block drive value
    input wire logic [7:0] oe, // block drive enable
    input wire logic [7:0] drv, // board drive value
    input wire logic [7:0] drv_en, // board drive enable
    input wire logic [7:0] pull, // pull-up present
    output logic [7:0] lvl // resolved pin level
);
    logic [7:0] flip = 8'h55;
    // floating pins wander, so a stale level can never pass a read
    always_ff @(posedge clk) begin
        flip <= ~flip;
    end
    // block drive first, then board, then pull-up or wander
    assign lvl = (oe & out) | (~oe & drv_en & drv)
        | (~oe & ~drv_en & (pull | flip));
endmodule // gpalt_board

// ==== verif/gpalt_ports_tb_top.sv ====
// self-checking bench for the three-port pin block over wishbone
// assumes the checker is bound in and board models feed the pins
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_total++; $display("Error %s exp %h got %h", nm, e, g); end end
module gpalt_ports_tb_top;
    import gpalt_pkg::*;
    logic clk, rst, cyc, stb, we, ack, usb, clko, txe, txd, spi_en, adc_on;
    logic irqa, irqb, irqc;
    logic [5:0] adr, pcpu;
    logic [31:0] di, dout, rdw;
    logic [7:0] pa_i, pa_o, pa_e, pb_i, pb_o, pb_e, pc_i, pc_o, pc_e, asel;
    logic [7:0] pa_d, pa_de, pb_d, pb_de, pc_d, pc_de;
    logic [1:0] p_oe, p_out;
    logic [3:0] s_oe, s_drv;
    logic [2:0] chsel;
    int err_total, checks_done, cyc_cnt, n;
    gpalt_ports dut_u (.CORE_CLK(clk), .RESET(rst), .CE(1'b1), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(di),
        .DAT_O(dout), .ACK_O(ack), .PA_IN(pa_i), .PA_OUT(pa_o), .PA_OE(pa_e),
        .PB_IN(pb_i), .PB_OUT(pb_o), .PB_OE(pb_e), .PC_IN(pc_i),
        .PC_OUT(pc_o), .PC_OE(pc_e), .PC_PULLUP(pcpu), .IRQ_PORT_A(irqa),
        .IRQ_PORT_B(irqb), .IRQ_PORT_C(irqc), .USB_TX_ACTIVE(usb),
        .CLK_OUT_SRC(clko),
        .SCI_TX_EN(txe), .SCI_TXD(txd), .SERIAL_RX(), .TIMER_CLK_IN(),
        .TIMER_CAPTURE(), .PULSE_OE(p_oe), .PULSE_OUT(p_out), .SPI_EN(spi_en),
        .SPI_DRV_OE(s_oe), .SPI_DRV(s_drv), .SPI_PIN_IN(), .ADC_ON(adc_on),
        .ADC_CHSEL(chsel), .ANALOG_SEL(asel));
    gpalt_board pa_u (.clk(clk), .out(pa_o), .oe(pa_e), .drv(pa_d),
        .drv_en(pa_de), .pull(8'h00), .lvl(pa_i));
    gpalt_board pb_u (.clk(clk), .out(pb_o), .oe(pb_e), .drv(pb_d),
        .drv_en(pb_de), .pull(8'h00), .lvl(pb_i));
    gpalt_board pc_u (.clk(clk), .out(pc_o), .oe(pc_e), .drv(pc_d),
        .drv_en(pc_de), .pull({pcpu, 2'b00}), .lvl(pc_i));
    // clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // verdict and end of run
    task results;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // classic cycle, held until ack is sampled, data taken at that edge
    task wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        di <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdw = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task rchk(input string nm, input logic [3:0] idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        `CHK(nm, {24'h0, e}, rdw)
    endtask
    // set port A pins, then count request cycles over four edges
    task pulses(input logic [7:0] lvl, output int c);
        pa_d <= lvl;
        c = 0;
        repeat (4) begin
            @(posedge clk);
            if (irqa === 1'b1) c++;
        end
    endtask
    // hang guard, well above the under 150 cycles the tests need
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_total++;
            results;
        end
    end
    initial begin
        {cyc, stb, we, usb, clko, txe, txd, spi_en, adc_on} = '0;
        {adr, di, p_oe, p_out, s_oe, s_drv, chsel, pb_d, pc_d, pc_de} = '0;
        {err_total, checks_done, cyc_cnt} = '0;
        rst = 1'b1;
        pa_d = 8'ha5;
        pa_de = 8'hff;
        pb_de = 8'h3a;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        `CHK("pullups", 6'h3f, pcpu)
        `CHK("pa enable", 8'h00, pa_e)
        rchk("pa dir", IDX_PA_DIR, 8'h00);
        rchk("pa pins", IDX_PA_LATCH, 8'ha5);
        wb(1'b0, IDX_PC_LATCH, 8'h00);
        `CHK("pc pulled", 6'h3f, rdw[7:2])
        wb(1'b1, IDX_PA_LATCH, 8'h3c);
        rchk("pa pins", IDX_PA_LATCH, 8'ha5);
        // board lets go of pins before they turn to outputs
        pa_de <= 8'h0d;
        wb(1'b1, IDX_PA_DIR, 8'hf2);
        repeat (2) @(posedge clk);
        `CHK("pa enable", 8'hf2, pa_e)
        `CHK("pa drive", 8'h30, pa_o & pa_e)
        rchk("pa mixed", IDX_PA_LATCH, 8'h35);
        wb(1'b1, IDX_PC_DIR, 8'h03);
        wb(1'b1, IDX_PC_LATCH, 8'h01);
        repeat (2) @(posedge clk);
        `CHK("pc open drain", 2'b10, pc_e[1:0])
        wb(1'b1, 4'hf, 8'hff);
        rchk("unmapped", 4'hf, 8'h00);
        // pins 0-2 enabled, pin 1 is an output driving low
        wb(1'b1, IDX_IRQ_CFG1, 8'h07);
        pulses(8'ha5, n);
        `CHK("irq output pin", 0, n)
        pulses(8'ha1, n);
        `CHK("irq level", 3, n)
        pulses(8'ha5, n);
        `CHK("irq release", 1, n)
        for (int m = 1; m < 4; m++) begin
            wb(1'b1, IDX_IRQ_SENS, m[7:0]);
            pulses(8'ha4, n);
            `CHK("irq fall", (m > 1) ? 1 : 0, n)
            pulses(8'ha5, n);
            `CHK("irq rise", m[0] ? 1 : 0, n)
        end
        // port B pin 4 held low, port C pin 2 pulled up then driven low
        wb(1'b1, IDX_IRQ_CFG1, 8'h10);
        wb(1'b1, IDX_IRQ_CFG2, 8'h01);
        @(posedge clk);
        `CHK("irq b c idle", 2'b10, {irqb, irqc})
        pc_de <= 8'h04;
        repeat (2) @(posedge clk);
        `CHK("irq b c low", 2'b11, {irqb, irqc})
        wb(1'b1, IDX_IRQ_CFG1, 8'h00);
        pa_de <= 8'h0c;
        pb_d <= 8'h12;
        pc_de <= 8'h40;
        {usb, clko, txe, txd, spi_en} <= 5'h1f;
        {p_oe, p_out, s_oe, s_drv} <= 12'h511;
        wb(1'b1, IDX_MISC, 8'h03);
        repeat (2) @(posedge clk);
        `CHK("usb enable", 2'b11, {pa_e[0], pa_o[0]})
        `CHK("clock out", 2'b11, {pb_e[0], pb_o[0]})
        `CHK("serial tx", 2'b11, {pb_e[2], pb_o[2]})
        wb(1'b0, IDX_PC_LATCH, 8'h00);
        `CHK("spi input pin", 1'b0, rdw[6])
        adc_on <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            chsel <= c[2:0];
            repeat (2) @(posedge clk);
            `CHK("analog sel", 8'h01 << c, asel)
        end
        results;
    end
endmodule // gpalt_ports_tb_top
